/* File: logic/rx_copy_pkg.sv */
// Purpose: Shared constants for the receive host copy DMA
// Assumes: Byte offsets on the register port
// Notes: Single clock design
`default_nettype none
package rx_copy_pkg;
   localparam logic [7:0] OFS_HDA = 8'h88;
   localparam logic [7:0] OFS_FRAG = 8'h8c;
   localparam logic [7:0] OFS_LEN = 8'h90;
   localparam logic [7:0] OFS_FCNT = 8'h94;
   localparam logic [7:0] OFS_CUR = 8'h98;
   localparam logic [7:0] OFS_FST = 8'h9c;
   localparam logic [7:0] OFS_FEND = 8'ha0;
   localparam logic [7:0] OFS_STAT = 8'ha4;
   localparam logic [7:0] OFS_RAM = 8'ha8;
   localparam logic [7:0] OFS_MWP = 8'hac;
   localparam logic [7:0] OFS_THR = 8'hb0;
   localparam logic [7:0] OFS_PRE = 8'hbc;
   localparam int B_OWN = 19;
   localparam int B_HDR = 18;
   localparam int B_LFF = 17;
   localparam int B_FRAG = 16;
   localparam int S_OWN = 15;
   localparam int S_HDR = 14;
   localparam int S_FERR = 13;
   localparam int S_NSV = 12;
   localparam logic [7:0] THR_RST = 8'hff;
   localparam logic [10:0] PRE_RST = 11'h000;
   localparam logic [17:0] FST_128K = 18'h10000;
   localparam logic [17:0] FST_32K = 18'h04000;
   localparam logic [17:0] FST_16K = 18'h04000;
   localparam logic [17:0] FST_NONE = 18'h00000;
   localparam logic [1:0] MSZ_16K = 2'h1;
   localparam logic [1:0] MSZ_32K = 2'h2;
   localparam logic [1:0] MSZ_128K = 2'h3;
   localparam logic [15:0] DW_BYTES = 16'h0004;
   localparam logic [17:0] DW_STEP = 18'h00004;
   localparam logic [29:0] FRAG_STEP = 30'h00000002;
   localparam int FIFO_DEPTH = 32;
   localparam int RAM_WORDS = 2048;
   typedef enum {ST_IDLE, ST_FETCH, ST_COPY, ST_POST} dma_state_t;
endpackage : rx_copy_pkg
`default_nettype wire

/* File: logic/rx_host_copy_dma_regs.sv */
// Purpose: Receive copy DMA from local receive RAM to host buffers
// Assumes: Register port and MAC side on sys_clk
// Notes: Single clock copy engine
// Function
// [RULE1] Fragment list pointer holds next entry address, low two bits read zero.
// [RULE2] Buffer length counts down by bytes written per data write.
// [RULE3] Length field holds frame offset where a fragment list copy starts.
// [RULE4] Owner bit shows last descriptor owner, read only, written via status.
// [RULE5] Flags mark header copy descriptor and fragment list descriptor.
// [RULE6] Format flag: 1 length before pointer, 0 pointer before length.
// [RULE7] Six bit fragment counter decrements just before each entry fetch.
// [RULE8] Eighteen bit current pointer holds receive RAM byte address in use.
// [RULE9] Frame start resets to memory start chosen by size setting.
// [RULE10] Frame start holds dword aligned start of current frame.
// [RULE11] Frame end holds dword past frame, low bits give valid bytes.
// [RULE12] Posted status word carries frame length in upper sixteen bits.
// [RULE13] Status owner bit is writable but reads and posts as zero.
// [RULE14] Status flags header copy and fragment list exhausted, read only.
// [RULE15] Network status valid set except after header copy or list error.
// [RULE16] Low status bits report monitor mode, broadcast and multicast hits.
// [RULE17] Missed bit when addressed frame dropped by monitor mode or overflow.
// [RULE18] CRC bit on mismatch or media error, not runts; alignment with CRC.
// [RULE19] Test port accesses RAM at current pointer, then steps one dword.
// [RULE20] MAC write pointer is write only dword address, reads undefined.
// [RULE21] Early warning pulse once per frame after threshold bytes copied.
// [RULE22] Packet interrupt pulse set distance in bytes before frame end.
// [RULE23] Host address upper bits step per dword, low bits give alignment.
// [RULE24] Exhausted buffer fetches next entry or descriptor before continuing.
`default_nettype none

module rx_word_fifo #(
   parameter int WIDTH = 62,
   parameter int DEPTH = rx_copy_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0] cnt;
   logic push;
   logic pop;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign in_ready = cnt != FULL;
   assign out_valid = cnt != '0;
   assign out_data = mem[rp];
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else begin
         if (push) begin
            wp <= wp + 1'b1;
         end
         if (pop) begin
            rp <= rp + 1'b1;
         end
         if (push && !pop) begin
            cnt <= cnt + 1'b1;
         end else if (pop && !push) begin
            cnt <= cnt - 1'b1;
         end
      end
   end
endmodule : rx_word_fifo

module rx_host_copy_dma_regs #(
   parameter int RAM_WORDS = rx_copy_pkg::RAM_WORDS
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   // Memory size pins
   input wire logic [1:0] mem_size_pin,
   // Receive MAC
   input wire logic mac_we,
   input wire logic [31:0] mac_wdata,
   input wire logic mac_frame_done,
   input wire logic [15:0] mac_frame_len,
   input wire logic mac_monitor,
   input wire logic mac_bcast,
   input wire logic mac_mcast,
   input wire logic mac_addr_ok,
   input wire logic mac_overflow,
   input wire logic mac_crc_bad,
   input wire logic mac_rx_err,
   input wire logic mac_runt,
   input wire logic mac_misaligned,
   input wire logic mac_intact,
   // Entry fetch
   output logic fetch_req,
   output logic [31:0] fetch_addr,
   input wire logic fetch_done,
   input wire logic [31:0] fetch_word0,
   input wire logic [31:0] fetch_word1,
   // Host data writes
   output logic host_wr_valid,
   output logic [29:0] host_wr_addr,
   output logic [31:0] host_wr_data,
   input wire logic host_wr_ready,
   // Status post and events
   output logic status_post_valid,
   output logic [31:0] status_post_word,
   output logic early_rx_irq,
   output logic pkt_rx_irq
);
   localparam int RA = $clog2(RAM_WORDS);
   rx_copy_pkg::dma_state_t state;
   logic [31:0] ram [RAM_WORDS];
   logic [29:0] frag_ptr;
   logic own, hdr, lff, fl;
   logic [15:0] blen;
   logic [5:0] fcnt;
   logic [17:0] cur;
   logic [15:0] fst;
   logic [17:0] fend;
   logic [15:0] flen;
   logic hdr_cp, ferr, nsv;
   logic [6:0] net;
   logic [15:0] mwp;
   logic [7:0] thr;
   logic [10:0] pre;
   logic [31:0] hda;
   logic pending, early_done, pre_done;
   logic [15:0] copied;
   logic [1:0] msz_s1, msz_s2, strap_cnt;
   logic strap_done;
   logic [31:0] next_rdata;
   logic [15:0] dw_b, nbytes, e_len, frame_left;
   logic [31:0] e_ptr;
   logic last_dw, take, full_dw, go_fetch, start, fin, crc, counting;
   logic sw_ram_wr, sw_ram_rd, f_in_ready, f_out_valid;
   logic [61:0] f_out;

   assign sw_ram_wr = reg_wr && reg_addr == rx_copy_pkg::OFS_RAM;
   assign sw_ram_rd = reg_rd && reg_addr == rx_copy_pkg::OFS_RAM;
   // Byte count of the dword under the pointer
   // [RULE11] valid bytes in last
   assign last_dw = (cur[17:2] + 16'h0001) == fend[17:2];
   assign dw_b = (last_dw && fend[1:0] != 2'h0) ? {14'h0, fend[1:0]} : rx_copy_pkg::DW_BYTES;
   assign nbytes = (blen < dw_b) ? blen : dw_b;
   assign full_dw = nbytes == dw_b;
   assign take = state == rx_copy_pkg::ST_COPY && blen != 16'h0 && f_in_ready;
   assign fin = take && last_dw && full_dw;
   // [RULE24] refill before continuing
   assign go_fetch = state == rx_copy_pkg::ST_COPY && blen == 16'h0 && !hdr && !(fl && fcnt == 6'h0);
   assign start = state == rx_copy_pkg::ST_IDLE && pending && own;
   // [RULE6] entry layout select
   assign e_len = lff ? fetch_word0[15:0] : fetch_word1[15:0];
   assign e_ptr = lff ? fetch_word1 : fetch_word0;
   assign frame_left = flen - copied;
   // Post cycle still counts: last dword lands then
   assign counting = state == rx_copy_pkg::ST_COPY || state == rx_copy_pkg::ST_POST;
   assign crc = (mac_crc_bad || mac_rx_err) && !mac_runt;

   // Strap sampled after release through two flops
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         msz_s1 <= 2'h0;
         msz_s2 <= 2'h0;
         strap_cnt <= 2'h0;
         strap_done <= 1'b0;
      end else begin
         msz_s1 <= mem_size_pin;
         msz_s2 <= msz_s1;
         if (strap_cnt != 2'h3) begin
            strap_cnt <= strap_cnt + 2'h1;
         end else begin
            strap_done <= 1'b1;
         end
      end
   end

   // Local receive RAM
   always_ff @(posedge sys_clk) begin
      // [RULE19] test port write
      if (sw_ram_wr) begin
         ram[cur[RA+1:2]] <= reg_wdata;
      end else if (mac_we) begin
         ram[mwp[RA-1:0]] <= mac_wdata;
      end
   end

   // [RULE20] MAC write pointer
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         mwp <= 16'h0;
      end else if (reg_wr && reg_addr == rx_copy_pkg::OFS_MWP) begin
         mwp <= reg_wdata[15:0];
      end else if (mac_we) begin
         mwp <= mwp + 16'h0001;
      end
   end

   // Threshold and preemptive distance
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         thr <= rx_copy_pkg::THR_RST;
         pre <= rx_copy_pkg::PRE_RST;
      end else if (reg_wr) begin
         if (reg_addr == rx_copy_pkg::OFS_THR) begin
            thr <= reg_wdata[9:2];
         end
         if (reg_addr == rx_copy_pkg::OFS_PRE) begin
            pre <= reg_wdata[10:0];
         end
      end
   end

   // Copy state machine
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state <= rx_copy_pkg::ST_IDLE;
      end else begin
         unique case (state)
            rx_copy_pkg::ST_IDLE: begin
               if (start) begin
                  state <= (fl && fcnt == 6'h0) ? rx_copy_pkg::ST_POST
                        : fl ? rx_copy_pkg::ST_FETCH : rx_copy_pkg::ST_COPY;
               end
            end
            rx_copy_pkg::ST_FETCH: begin
               if (fetch_done) begin
                  state <= rx_copy_pkg::ST_COPY;
               end
            end
            rx_copy_pkg::ST_COPY: begin
               if (fin || (blen == 16'h0 && !go_fetch)) begin
                  state <= rx_copy_pkg::ST_POST;
               end else if (go_fetch) begin
                  state <= rx_copy_pkg::ST_FETCH;
               end
            end
            rx_copy_pkg::ST_POST: begin
               state <= rx_copy_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Length and control word
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         own <= 1'b0;
         hdr <= 1'b0;
         lff <= 1'b0;
         fl <= 1'b0;
         blen <= 16'h0;
      end else begin
         // [RULE5] header and list flags
         if (reg_wr && reg_addr == rx_copy_pkg::OFS_LEN) begin
            hdr <= reg_wdata[rx_copy_pkg::B_HDR];
            lff <= reg_wdata[rx_copy_pkg::B_LFF];
            fl <= reg_wdata[rx_copy_pkg::B_FRAG];
            blen <= reg_wdata[15:0];
         end else if (start && fl) begin
            blen <= 16'h0;
         end else if (state == rx_copy_pkg::ST_FETCH && fetch_done) begin
            blen <= e_len;
         end else if (take) begin
            // [RULE2] count down
            blen <= blen - nbytes;
         end
         // [RULE4] owner via status port
         if (reg_wr && reg_addr == rx_copy_pkg::OFS_STAT) begin
            own <= reg_wdata[rx_copy_pkg::S_OWN];
         end else if (state == rx_copy_pkg::ST_POST) begin
            own <= 1'b0;
         end
      end
   end

   // Fragment pointer, count and host address
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         frag_ptr <= 30'h0;
         fcnt <= 6'h0;
         hda <= 32'h0;
      end else begin
         // [RULE1] dword aligned pointer
         if (reg_wr && reg_addr == rx_copy_pkg::OFS_FRAG) begin
            frag_ptr <= reg_wdata[31:2];
         end else if (state == rx_copy_pkg::ST_FETCH && fetch_done && fl) begin
            frag_ptr <= frag_ptr + rx_copy_pkg::FRAG_STEP;
         end
         // [RULE7] decrement before fetch
         if (reg_wr && reg_addr == rx_copy_pkg::OFS_FCNT) begin
            fcnt <= reg_wdata[5:0];
         end else if (fl && ((start && fcnt != 6'h0) || go_fetch)) begin
            fcnt <= fcnt - 6'h1;
         end
         // [RULE23] dword address steps
         if (reg_wr && reg_addr == rx_copy_pkg::OFS_HDA) begin
            hda <= reg_wdata;
         end else if (state == rx_copy_pkg::ST_FETCH && fetch_done) begin
            hda <= e_ptr;
         end else if (take) begin
            hda[31:2] <= hda[31:2] + 30'h1;
         end
      end
   end

   // Receive RAM pointers
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cur <= 18'h0;
         fst <= 16'h0;
         fend <= 18'h0;
      end else begin
         // [RULE8] current byte address
         if (reg_wr && reg_addr == rx_copy_pkg::OFS_CUR) begin
            cur <= reg_wdata[17:0];
         end else if (sw_ram_wr || sw_ram_rd) begin
            // [RULE19] step one dword
            cur <= cur + rx_copy_pkg::DW_STEP;
         end else if (start) begin
            // [RULE3] offset held in length
            cur <= {fst, 2'h0} + (fl ? {2'h0, blen[15:2], 2'h0} : 18'h0);
         end else if (take && full_dw) begin
            cur <= cur + rx_copy_pkg::DW_STEP;
         end
         // [RULE9] start of memory by size
         if (!strap_done && strap_cnt == 2'h3) begin
            unique case (msz_s2)
               rx_copy_pkg::MSZ_128K: fst <= rx_copy_pkg::FST_128K[17:2];
               rx_copy_pkg::MSZ_32K: fst <= rx_copy_pkg::FST_32K[17:2];
               rx_copy_pkg::MSZ_16K: fst <= rx_copy_pkg::FST_16K[17:2];
               default: fst <= rx_copy_pkg::FST_NONE[17:2];
            endcase
         end else if (reg_wr && reg_addr == rx_copy_pkg::OFS_FST) begin
            fst <= reg_wdata[17:2];
         end else if (state == rx_copy_pkg::ST_POST) begin
            // [RULE10] next frame start
            fst <= fend[17:2];
         end
         if (reg_wr && reg_addr == rx_copy_pkg::OFS_FEND) begin
            fend <= reg_wdata[17:0];
         end else if (mac_frame_done) begin
            fend <= {mwp, mac_frame_len[1:0]};
         end
      end
   end

   // Frame status from MAC and DMA
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pending <= 1'b0;
         flen <= 16'h0;
         net <= 7'h0;
         hdr_cp <= 1'b0;
         ferr <= 1'b0;
         nsv <= 1'b0;
      end else begin
         if (mac_frame_done) begin
            pending <= 1'b1;
            // [RULE12] frame length
            flen <= mac_frame_len;
            // [RULE16] monitor, broadcast, multicast
            net[6] <= mac_monitor;
            net[5] <= mac_bcast;
            net[4] <= mac_mcast;
            // [RULE17] dropped addressed frame
            net[3] <= mac_addr_ok && (mac_monitor || mac_overflow);
            // [RULE18] crc and alignment
            net[2] <= crc;
            net[1] <= crc && mac_misaligned;
            net[0] <= mac_intact;
            hdr_cp <= 1'b0;
            ferr <= 1'b0;
            nsv <= 1'b1;
         end else if (state == rx_copy_pkg::ST_POST) begin
            pending <= 1'b0;
         end else if (state == rx_copy_pkg::ST_COPY && blen == 16'h0 && !go_fetch && !fin) begin
            // [RULE14] header copy or list error
            hdr_cp <= hdr;
            ferr <= !hdr;
            // [RULE15] valid unless these cases
            nsv <= 1'b0;
         end else if (start && fl && fcnt == 6'h0) begin
            ferr <= 1'b1;
            nsv <= 1'b0;
         end
      end
   end

   // Early warning and preemptive events
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         copied <= 16'h0;
         early_done <= 1'b0;
         pre_done <= 1'b0;
         early_rx_irq <= 1'b0;
         pkt_rx_irq <= 1'b0;
      end else begin
         early_rx_irq <= 1'b0;
         pkt_rx_irq <= 1'b0;
         if (start) begin
            copied <= 16'h0;
            early_done <= 1'b0;
            pre_done <= 1'b0;
         end else begin
            if (take) begin
               copied <= copied + nbytes;
            end
            // [RULE21] once per frame
            if (counting && !early_done && copied >= {6'h0, thr, 2'h0}) begin
               early_done <= 1'b1;
               early_rx_irq <= 1'b1;
            end
            // [RULE22] distance before end
            if (counting && !pre_done && frame_left <= {5'h0, pre}) begin
               pre_done <= 1'b1;
               pkt_rx_irq <= 1'b1;
            end
         end
      end
   end

   // Fetch request and status post
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         fetch_req <= 1'b0;
         fetch_addr <= 32'h0;
         status_post_valid <= 1'b0;
         status_post_word <= 32'h0;
      end else begin
         fetch_req <= state == rx_copy_pkg::ST_FETCH && !fetch_done;
         fetch_addr <= {frag_ptr, 2'h0};
         status_post_valid <= state == rx_copy_pkg::ST_POST;
         // [RULE13] owner posts as zero
         if (state == rx_copy_pkg::ST_POST) begin
            status_post_word <= {flen, 1'b0, hdr_cp, ferr, nsv, 5'h0, net};
         end
      end
   end

   // Register read
   always_comb begin
      next_rdata = 32'h0;
      unique case (reg_addr)
         rx_copy_pkg::OFS_HDA: next_rdata = hda;
         rx_copy_pkg::OFS_FRAG: next_rdata = {frag_ptr, 2'h0};
         rx_copy_pkg::OFS_LEN: next_rdata = {12'h0, own, hdr, lff, fl, blen};
         rx_copy_pkg::OFS_FCNT: next_rdata = {26'h0, fcnt};
         rx_copy_pkg::OFS_CUR: next_rdata = {14'h0, cur};
         rx_copy_pkg::OFS_FST: next_rdata = {14'h0, fst, 2'h0};
         rx_copy_pkg::OFS_FEND: next_rdata = {14'h0, fend};
         rx_copy_pkg::OFS_STAT: next_rdata = {flen, 1'b0, hdr_cp, ferr, nsv, 5'h0, net};
         rx_copy_pkg::OFS_RAM: next_rdata = ram[cur[RA+1:2]];
         rx_copy_pkg::OFS_THR: next_rdata = {22'h0, thr, 2'h0};
         rx_copy_pkg::OFS_PRE: next_rdata = {21'h0, pre};
         default: next_rdata = 32'h0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 32'h0;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // Host data path through the word buffer
   rx_word_fifo #(.WIDTH(62), .DEPTH(rx_copy_pkg::FIFO_DEPTH)) u_fifo (
      .clk(sys_clk),
      .rstn(rstn),
      .in_valid(take),
      .in_data({hda[31:2], ram[cur[RA+1:2]]}),
      .in_ready(f_in_ready),
      .out_valid(f_out_valid),
      .out_data(f_out),
      .out_ready(!host_wr_valid || host_wr_ready)
   );

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         host_wr_valid <= 1'b0;
         host_wr_addr <= 30'h0;
         host_wr_data <= 32'h0;
      end else if (!host_wr_valid || host_wr_ready) begin
         host_wr_valid <= f_out_valid;
         host_wr_addr <= f_out[61:32];
         host_wr_data <= f_out[31:0];
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   AST_FRAG_LOW: assert property (reg_rvalid && $past(reg_addr) == rx_copy_pkg::OFS_FRAG |-> reg_rdata[1:0] == 2'h0) else $error("frag pointer low bits set"); // [RULE1]
   AST_LEN_DOWN: assert property (take |=> blen == $past(blen) - $past(nbytes)) else $error("length did not count down"); // [RULE2]
   AST_FCNT_DEC: assert property (go_fetch && fl |=> fcnt == $past(fcnt) - 6'h1) else $error("fragment count not decremented"); // [RULE7]
   AST_CUR_STEP: assert property (sw_ram_rd |=> cur == $past(cur) + rx_copy_pkg::DW_STEP) else $error("test port did not step"); // [RULE19]
   AST_POST_OWN: assert property (status_post_valid |-> !status_post_word[15]) else $error("posted owner not host"); // [RULE13]
   AST_POST_LEN: assert property (state == rx_copy_pkg::ST_POST |=> status_post_valid && status_post_word[31:16] == $past(flen)) else $error("bad posted length"); // [RULE12]
   AST_NSV: assert property (status_post_valid && !status_post_word[14] && !status_post_word[13] |-> status_post_word[12]) else $error("status valid missing"); // [RULE15]
   AST_EARLY_ONCE: assert property (early_rx_irq |=> (!early_rx_irq)[*8]) else $error("early warning repeated"); // [RULE21]
   AST_HDA_INC: assert property (take |=> hda[31:2] == $past(hda[31:2]) + 30'h1) else $error("host address not stepped"); // [RULE23]
   COV_FRAME: cover property (start ##[1:200] status_post_valid);
   COV_FERR: cover property (status_post_valid && status_post_word[13]);
   COV_FETCH: cover property (fetch_req ##1 fetch_done);
endmodule : rx_host_copy_dma_regs
`default_nettype wire

/* File: sim/host_mem_model.sv */
// Purpose: Host memory side of the receive copy DMA
// Assumes: Entry fetch and data write handshakes of the block
// Notes: Accepts data writes with random stalls
`default_nettype none
module host_mem_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Entry fetch
   input wire logic fetch_req,
   output logic fetch_done,
   output logic [31:0] fetch_word0,
   output logic [31:0] fetch_word1,
   // Data writes
   input wire logic wr_valid,
   output logic wr_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   // Entry words garbled outside the answer cycle
   assign fetch_word0 = fetch_done ? 32'h0000_1000 : 32'hffff_efff;
   assign fetch_word1 = fetch_done ? 32'h0000_0100 : 32'hffff_feff;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fetch_done <= 1'b0;
         wr_ready <= 1'b0;
      end else begin
         fetch_done <= fetch_req && !fetch_done;
         wr_ready <= ($urandom % 4) != 0;
      end
   end
endmodule : host_mem_model
`default_nettype wire

/* File: sim/tb.sv */
// Purpose: Self checking bench for the receive copy DMA
// Assumes: No external memory strap
// Notes: Fixed seed
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, reg_rvalid, mac_we = 0;
   logic [7:0] reg_addr = 0;
   logic [31:0] reg_wdata = 0, reg_rdata, mac_wdata = 0, fetch_addr, fetch_word0, fetch_word1;
   logic [1:0] mem_size_pin = 0;
   logic mac_frame_done = 0, mac_monitor = 0, mac_bcast = 0, mac_mcast = 0, mac_addr_ok = 0;
   logic mac_overflow = 0, mac_crc_bad = 0, mac_rx_err = 0, mac_runt = 0;
   logic mac_misaligned = 0, mac_intact = 0, fetch_req, fetch_done, host_wr_valid;
   logic [15:0] mac_frame_len = 0;
   logic [29:0] host_wr_addr, exp_a;
   logic [31:0] host_wr_data, status_post_word, d, exp_q[$];
   logic host_wr_ready, status_post_valid, early_rx_irq, pkt_rx_irq;
   int n_mismatch = 0, compares = 0, cyc = 0, tot = 0;
   int nb = 0, nf = 0, n_early = 0, e_early = 0, n_pkt = 0;
   rx_host_copy_dma_regs dut_u (.sys_clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .reg_rvalid, .mem_size_pin, .mac_we, .mac_wdata, .mac_frame_done,
      .mac_frame_len, .mac_monitor, .mac_bcast, .mac_mcast, .mac_addr_ok, .mac_overflow,
      .mac_crc_bad, .mac_rx_err, .mac_runt, .mac_misaligned, .mac_intact, .fetch_req,
      .fetch_addr, .fetch_done, .fetch_word0, .fetch_word1, .host_wr_valid, .host_wr_addr,
      .host_wr_data, .host_wr_ready, .status_post_valid, .status_post_word, .early_rx_irq,
      .pkt_rx_irq);
   host_mem_model mem_u (.clk(sys_clk), .rstn, .fetch_req, .fetch_done, .fetch_word0,
      .fetch_word1, .wr_valid(host_wr_valid), .wr_ready(host_wr_ready));
   initial forever #2.5 sys_clk = ~sys_clk;
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 0;
      #1;
      chk(reg_rdata, e);
   endtask : rd
   // Expected network bits from monitor,bcast,mcast,addr,ovf,crc,rxerr,runt,misal,intact
   function automatic logic [6:0] net(input logic [9:0] s);
      logic crc;
      crc = (s[4] | s[3]) & ~s[2];
      return {s[9], s[8], s[7], s[6] & (s[9] | s[5]), crc, crc & s[1], s[0]};
   endfunction : net
   task automatic frame(input int n);
      logic [9:0] s;
      logic [15:0] len;
      s = 10'($urandom);
      len = 16'(4 * n - ($urandom % 4));
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         d = $urandom;
         exp_q.push_back(d);
         mac_we <= 1;
         mac_wdata <= d;
      end
      @(posedge sys_clk);
      mac_we <= 0;
      mac_frame_done <= 1;
      mac_frame_len <= len;
      {mac_monitor, mac_bcast, mac_mcast, mac_addr_ok, mac_overflow, mac_crc_bad,
       mac_rx_err, mac_runt, mac_misaligned, mac_intact} <= s;
      @(posedge sys_clk);
      mac_frame_done <= 0;
      tot += n;
      nb += len;
      nf++;
      e_early += (len >= 16'd16);
      wr(8'ha4, 32'h8000);
      for (int k = 0; k < 500 && status_post_valid !== 1'b1; k++) begin
         @(posedge sys_clk);
         #1;
      end
      d = {len, 4'b0001, 5'h0, net(s)};
      chk(status_post_word, d);
      rd(8'ha4, d);
      rd(8'h90, 32'(16'(16'h0800 - nb)));
      rd(8'h9c, 32'(tot * 4));
      rd(8'ha0, 32'(tot * 4 + len[1:0]));
      chk(n_early, e_early);
      chk(n_pkt, nf);
   endtask : frame
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude();
      end
      if (early_rx_irq === 1'b1) n_early++;
      if (pkt_rx_irq === 1'b1) n_pkt++;
      if (host_wr_valid && host_wr_ready) begin
         chk(32'(host_wr_addr), 32'(exp_a));
         chk(host_wr_data, exp_q.pop_front());
         exp_a = exp_a + 30'h1;
      end
   end
   initial begin
      void'($urandom(98237));
      repeat (20) @(posedge sys_clk);
      rstn <= 1;
      repeat (5) @(posedge sys_clk);
      d = $urandom;
      rd(8'h9c, 0);
      wr(8'h8c, d);
      rd(8'h8c, d & 32'hffff_fffc);
      wr(8'h94, d);
      rd(8'h94, d & 32'h3f);
      rd(8'hac, 0);
      rd(8'hbc, 0);
      rd(8'h84, 0);
      $display("test registers done");
      wr(8'h98, 32'h400);
      wr(8'ha8, d);
      wr(8'ha8, ~d);
      rd(8'h98, 32'h408);
      wr(8'h98, 32'h404);
      rd(8'ha8, ~d);
      $display("test ram port done");
      wr(8'hac, 0);
      wr(8'h88, 32'h1000);
      wr(8'h90, 32'h800);
      wr(8'hb0, 32'h10);
      exp_a = 30'h400;
      for (int f = 0; f < 3; f++) frame(f * 5 + 1 + $urandom % 4);
      repeat (50) @(posedge sys_clk);
      chk(exp_q.size(), 0);
      $display("test frames done");
      conclude();
   end
endmodule : tb
`default_nettype wire
